// File: hdl/drt_rom_table.sv
// Purpose: Debug component directory with identification registers
// Assumes: APB slave, zero wait states, one 4KB block
// Notes:   All registers read-only, writes accepted and dropped
//
// Function
// - Component ident bytes 0x0D, class 0x1, 0x05
// - Component ident words at 0xFF0 to 0xFFC
// - Memory kind register 0xFCC, bit 0 only
// - Bit 0 set when system memory shares bus
// - Avoid reporting system memory; zero always allowed
// - Peripheral ident words at 0xFD0 to 0xFEC
// - Part number, designer code, JEDEC bit layout
// - Revision, customer modified, metal fix fields
// - Size field zero: one 4KB block
// - No domain numbers on requesters or without one
// - Requester shares the directory's power domain
// - Five-bit domain, zero unless valid
// - Bit 0 of entry marks presence
//
// Decided for this implementation: the APB interface to the registers.
`include "drt_map.svh"
module drt_rom_table #(
    parameter int              N_ENTRIES    = 3,
    parameter logic [N_ENTRIES*20-1:0] OFFSETS = {20'h00003, 20'h00002, 20'h00001},
    parameter logic [N_ENTRIES-1:0]    PRESENT = 3'b111,
    parameter logic [N_ENTRIES-1:0]    PVALID  = 3'b110,
    parameter logic [N_ENTRIES*5-1:0]  PIDS    = {5'h01, 5'h00, 5'h00},
    parameter logic [N_ENTRIES-1:0]    REQ     = 3'b001,
    parameter logic            ALLOW_SYSTEM_MEMORY_ON_BUS = `DRT_SYSTEM_MEMORY_ON_BUS_RST,
    parameter logic [11:0]     PART_NUM     = 12'h001, // Arbitrary value
    parameter logic [6:0]      DESIGNER_ID  = 7'h01,   // Arbitrary value
    parameter logic [3:0]      DESIGNER_CNT = 4'h0,    // Arbitrary value
    parameter logic [3:0]      REVISION     = 4'h0,
    parameter logic [3:0]      CUST_MOD     = 4'h0,
    parameter logic [3:0]      METAL_FIX    = 4'h0,
    parameter logic [7:0]      CID3_VAL     = 8'h00    // Arbitrary value
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        system_memory_on_bus_pin
);
    import drt_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Declarations
    logic          system_memory_on_bus_meta;   // First synchroniser stage
    logic          system_memory_on_bus_sync;   // Second synchroniser stage
    logic          system_memory_on_bus; // Reported bit
    drt_entry_t    entry_word;    // Entry at current index
    drt_designer_t designer;      // Designer code fields
    logic [11:0]   word_addr;     // Aligned byte address
    logic          setup_phase;   // APB setup cycle
    logic          write_seen;    // Write data has a bit set

    assign word_addr   = {paddr[11:2], 2'b00};
    assign setup_phase = psel && !penable;
    assign designer    = {DESIGNER_CNT, DESIGNER_ID[6:4], DESIGNER_ID[3:0]};
    assign write_seen  = |pwdata;

    ////////////////////////////////////////////////////////////////
    // Strap synchroniser for the system memory pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_memory_on_bus_meta <= `DRT_SYSTEM_MEMORY_ON_BUS_RST;
            system_memory_on_bus_sync <= `DRT_SYSTEM_MEMORY_ON_BUS_RST;
        end else begin
            system_memory_on_bus_meta <= system_memory_on_bus_pin;
            system_memory_on_bus_sync <= system_memory_on_bus_meta;
        end
    end

    // Deprecated setting only reported when built to allow it
    assign system_memory_on_bus = ALLOW_SYSTEM_MEMORY_ON_BUS & system_memory_on_bus_sync;

    ////////////////////////////////////////////////////////////////
    // Directory entries
    drt_entry_table #(
        .N_ENTRIES (N_ENTRIES),
        .OFFSETS   (OFFSETS),
        .PRESENT   (PRESENT),
        .PVALID    (PVALID),
        .PIDS      (PIDS),
        .REQ       (REQ)
    ) u_entries (
        .index      (paddr[11:2]),
        .entry_word (entry_word)
    );

    ////////////////////////////////////////////////////////////////
    // Read decode
    function automatic logic [31:0] read_word(input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            // Memory kind, bits 31:1 zero
            `DRT_OFS_MEMKIND: w = {31'h0, system_memory_on_bus};
            // Designer continuation and size
            `DRT_OFS_PID4: w = {24'h0, `DRT_PID4_SIZE, designer.cont};
            // Upper peripheral words read zero
            `DRT_OFS_PID5, `DRT_OFS_PID6, `DRT_OFS_PID7: w = 32'h0;
            // Part number low byte
            `DRT_OFS_PID0: w = {24'h0, PART_NUM[7:0]};
            // Designer low bits and part number high
            `DRT_OFS_PID1: w = {24'h0, designer.id_lo, PART_NUM[11:8]};
            // Revision, JEDEC flag, designer high bits
            `DRT_OFS_PID2: w = {24'h0, REVISION, `DRT_PID2_JEDEC,
                                designer.id_hi};
            // Metal fix and customer modified
            `DRT_OFS_PID3: w = {24'h0, METAL_FIX, CUST_MOD};
            // Component ident preamble and class
            `DRT_OFS_CID0: w = {24'h0, `DRT_CID0_VAL};
            `DRT_OFS_CID1: w = {24'h0, `DRT_CID1_CLASS, `DRT_CID1_PRE};
            `DRT_OFS_CID2: w = {24'h0, `DRT_CID2_VAL};
            `DRT_OFS_CID3: w = {24'h0, CID3_VAL};
            default: begin
                // Entry area; reserved area reads zero
                if (a <= `DRT_OFS_LAST_ENTRY) begin
                    w = entry_word;
                end
            end
        endcase
        return w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////
    // Read data register, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            // Writes load zero, nothing is stored
            if (pwrite) begin
                prdata <= 32'h0000_0000;
            end else begin
                prdata <= read_word(word_addr);
            end
        end
    end

    // Zero wait states, never an error
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    ////////////////////////////////////////////////////////////////
    // Assertion helpers
    logic rd_acc;  // Read access phase
    logic wr_acc;  // Write access phase
    logic in_dir;  // Address in entry area
    logic is_req;  // Address names a requester entry
    assign rd_acc = psel && penable && !pwrite;
    assign wr_acc = psel && penable && pwrite;
    assign in_dir = word_addr <= `DRT_OFS_LAST_ENTRY;
    assign is_req = (int'(paddr[11:2]) < N_ENTRIES) &&
                    REQ[paddr[11:2] % N_ENTRIES];

    ////////////////////////////////////////////////////////////////
    // Assertions
    a_cid_preamble0: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && word_addr == `DRT_OFS_CID0 |-> prdata == 32'h0000_000D)
        else $error("component ident word0 wrong");

    a_cid_class_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && word_addr == `DRT_OFS_CID1 |-> prdata == 32'h0000_0010)
        else $error("component class field wrong");

    a_cid_block_end: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && word_addr == `DRT_OFS_CID2
        ##1 psel && penable |-> prdata == 32'h0000_0005)
        else $error("component ident word2 wrong");

    a_memkind_upper: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && word_addr == `DRT_OFS_MEMKIND |-> prdata[31:1] == 31'h0)
        else $error("memory kind upper bits not zero");

    a_memkind_system_memory_on_bus: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && word_addr == `DRT_OFS_MEMKIND && $past(presetn, 3)
        |-> prdata[0] == (ALLOW_SYSTEM_MEMORY_ON_BUS && $past(system_memory_on_bus_pin, 3)))
        else $error("system memory bit not from strap");

    a_system_memory_on_bus_default: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && word_addr == `DRT_OFS_MEMKIND && !ALLOW_SYSTEM_MEMORY_ON_BUS
        |-> !prdata[0])
        else $error("system memory reported while disallowed");

    a_pid_high_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && (word_addr == `DRT_OFS_PID5 || word_addr == `DRT_OFS_PID7)
        |-> prdata == 32'h0)
        else $error("peripheral ident high word not zero");

    a_pid_jedec_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && word_addr == `DRT_OFS_PID2
        |-> prdata[3] && prdata[31:8] == 24'h0)
        else $error("jedec flag or upper bits wrong");

    a_pid_revision: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && word_addr == `DRT_OFS_PID3
        |-> prdata == {24'h0, METAL_FIX, CUST_MOD})
        else $error("revision fields wrong");

    a_pid_size_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && word_addr == `DRT_OFS_PID4 |-> prdata[31:4] == 28'h0)
        else $error("size field not zero");

    a_requester_no_dom: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && (is_req || (REQ & PRESENT) == '0) |-> !prdata[2])
        else $error("requester or orphan entry has a domain");

    a_domain_raz: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && in_dir && !prdata[2] |-> prdata[8:4] == 5'h00)
        else $error("domain number set without valid flag");

    a_absent_no_dom: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && in_dir && !prdata[0] |-> prdata[8:2] == 7'h00)
        else $error("absent entry carries a domain");

    a_write_no_error: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && write_seen |-> pready && !pslverr && prdata == 32'h0)
        else $error("write not answered cleanly");

endmodule : drt_rom_table

// File: common/drt_map.svh
// Purpose: Offsets, field positions, fixed values of the directory block
// Assumes: Byte offsets within one 4KB block, word aligned
// Notes:   Definitions only
`ifndef DRT_MAP_SVH
`define DRT_MAP_SVH

// Register byte offsets
`define DRT_OFS_LAST_ENTRY 12'hEFC
`define DRT_OFS_MEMKIND    12'hFCC
`define DRT_OFS_PID4       12'hFD0
`define DRT_OFS_PID5       12'hFD4
`define DRT_OFS_PID6       12'hFD8
`define DRT_OFS_PID7       12'hFDC
`define DRT_OFS_PID0       12'hFE0
`define DRT_OFS_PID1       12'hFE4
`define DRT_OFS_PID2       12'hFE8
`define DRT_OFS_PID3       12'hFEC
`define DRT_OFS_CID0       12'hFF0
`define DRT_OFS_CID1       12'hFF4
`define DRT_OFS_CID2       12'hFF8
`define DRT_OFS_CID3       12'hFFC

// Directory geometry
`define DRT_MAX_ENTRIES    960
`define DRT_OFS_FIELD_W    20

// Entry field positions
`define DRT_ENT_PRESENT_BIT 0
`define DRT_ENT_PVALID_BIT  2
`define DRT_ENT_PID_LSB     4
`define DRT_ENT_PID_MSB     8

// Fixed identification values
`define DRT_CID0_VAL   8'h0D
`define DRT_CID1_PRE   4'h0
`define DRT_CID1_CLASS 4'h1
`define DRT_CID2_VAL   8'h05
`define DRT_PID2_JEDEC 1'b1
`define DRT_PID4_SIZE  4'h0
`define DRT_SYSTEM_MEMORY_ON_BUS_RST 1'b0

`endif

// File: common/drt_pkg.sv
// Purpose: Types shared by the directory block
// Assumes: 32-bit entry words
// Notes:   Offsets and values live in drt_map.svh
package drt_pkg;

    // One directory entry word
    typedef struct packed {
        logic [19:0] offset;      // Component offset, two's complement
        logic [2:0]  rsvd_hi;     // Reads zero
        logic [4:0]  pwr_id;      // Power domain number
        logic        rsvd_lo;     // Reads zero
        logic        pwr_valid;   // Domain number valid
        logic        fmt;         // 32-bit format, reads one
        logic        present;     // Entry present
    } drt_entry_t;

    // Designer code split into its three fields
    typedef struct packed {
        logic [3:0] cont;         // Continuation code
        logic [2:0] id_hi;        // Identity bits 6:4
        logic [3:0] id_lo;        // Identity bits 3:0
    } drt_designer_t;

endpackage : drt_pkg

// File: hdl/drt_entry_table.sv
// Purpose: Builds the directory entry word for one word index
// Assumes: Entry contents are fixed at build time
// Notes:   Pure combinational lookup
`include "drt_map.svh"
module drt_entry_table #(
    parameter int                N_ENTRIES = 3,
    parameter logic [N_ENTRIES*20-1:0] OFFSETS = {20'h00003, 20'h00002, 20'h00001},
    parameter logic [N_ENTRIES-1:0]    PRESENT = 3'b111,
    parameter logic [N_ENTRIES-1:0]    PVALID  = 3'b110,
    parameter logic [N_ENTRIES*5-1:0]  PIDS    = {5'h01, 5'h00, 5'h00},
    parameter logic [N_ENTRIES-1:0]    REQ     = 3'b001
) (
    input  wire logic [9:0]         index,
    output drt_pkg::drt_entry_t     entry_word
);
    import drt_pkg::*;

    // Any present power requester listed here
    logic has_requester;
    assign has_requester = |(REQ & PRESENT);

    ////////////////////////////////////////////////////////////////
    // Entry assembly
    function automatic drt_entry_t make_entry(input int i);
        drt_entry_t e;
        logic       pv;
        e = '0;
        // Requesters and absent entries never carry a domain
        pv = PVALID[i] & PRESENT[i] & ~REQ[i] & has_requester;
        e.offset    = OFFSETS[i*20 +: 20];
        e.fmt       = 1'b1;
        e.present   = PRESENT[i];
        e.pwr_valid = pv;
        // Domain number reads zero unless valid
        e.pwr_id    = pv ? PIDS[i*5 +: 5] : 5'h00;
        return e;
    endfunction : make_entry

    // Past the last entry the word is the zero end marker
    always_comb begin
        entry_word = '0;
        for (int i = 0; i < N_ENTRIES; i++) begin
            if (int'(index) == i) begin
                // Requester sits in this directory's own domain
                entry_word = make_entry(i);
            end
        end
    end

endmodule : drt_entry_table

// File: tb/drt_dbg_model.sv
// Purpose: Debugger model, APB master and power-domain discovery walk
// Assumes: Answer sampled at a pclk rise with pready high
// Notes:   Tasks are called from the bench; request stays up after a transfer
module drt_dbg_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    import drt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One transfer: setup, then access held until pready is seen high
    task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= adr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd  = prdata;
        err = pslverr;
    endtask : xfer

    // Bus back to idle
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : idle

    ////////////////////////////////////////////////////////////////////////////
    // Walk from the top; entries are read up to and including the zero end marker, memory kind never used
    task automatic walk(output logic [31:0] dom_mask, output int n_plain, output int n_bad);
        logic [31:0] w;
        logic        e;
        int          i;
        dom_mask = 32'h0;
        n_plain  = 0;
        n_bad    = 0;
        i        = 0;
        do begin
            xfer(1'b0, 12'(i * 4), 32'h0, w, e);
            if (w[0] === 1'b1 && w[2] === 1'b1) begin
                dom_mask[w[8:4]] = 1'b1;
            end else if (w[0] === 1'b1) begin
                n_plain++;
            end
            if (w[2] !== 1'b1 && w[8:4] !== 5'h00) begin
                n_bad++; // Number shown without valid flag
            end
            i++;
        end while (w !== 32'h0 && i < 960);
        idle();
    endtask : walk

endmodule : drt_dbg_model

// File: tb/testbench.sv
// Purpose: Self-checking bench of the directory block over APB
// Assumes: Zero-wait slave, strap synchronised in two edges
// Notes:   Identity values below are our own choice
module testbench;
    import drt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] P_PART = 12'h2A5; // Arbitrary value
    localparam logic [6:0]  P_DES  = 7'h3B;   // Arbitrary value
    localparam logic [3:0]  P_CNT  = 4'h6;    // Arbitrary value
    localparam logic [7:0]  P_CID3 = 8'hB1;   // Arbitrary value
    localparam logic [3:0]  P_REV  = 4'h2;
    localparam logic [3:0]  P_CUST = 4'h1;
    localparam logic [3:0]  P_FIX  = 4'h3;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, strap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          fail_count = 0;
    int          cmp_count  = 0;
    logic [11:0] adr_tab [13] = '{12'hFCC, 12'hFD0, 12'hFD4, 12'hFD8, 12'hFDC, 12'hFE0,
                                  12'hFE4, 12'hFE8, 12'hFEC, 12'hFF0, 12'hFF4, 12'hFF8, 12'hFFC};
    logic [31:0] exp_tab [13] = '{32'h0, {28'h0, P_CNT}, 32'h0, 32'h0, 32'h0,
                                  {24'h0, P_PART[7:0]}, {24'h0, P_DES[3:0], P_PART[11:8]},
                                  {24'h0, P_REV, 1'b1, P_DES[6:4]}, {24'h0, P_FIX, P_CUST},
                                  32'h0D, 32'h10, 32'h05, {24'h0, P_CID3}};
    logic [31:0] ent_tab [4]  = '{32'h00001003, 32'h00002007, 32'h00003017, 32'h0};
    logic [11:0] zero_tab [4] = '{12'h100, 12'hEFC, 12'hF00, 12'hFC8};

    // Block under test, system memory reporting allowed
    drt_rom_table #(.ALLOW_SYSTEM_MEMORY_ON_BUS(1'b1), .PART_NUM(P_PART), .DESIGNER_ID(P_DES),
        .DESIGNER_CNT(P_CNT), .REVISION(P_REV), .CUST_MOD(P_CUST), .METAL_FIX(P_FIX),
        .CID3_VAL(P_CID3)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .system_memory_on_bus_pin(strap));

    // Debugger on the far side
    drt_dbg_model i_dbg (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    ////////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Compare and count
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : check

    // Counts and verdict
    task automatic summarize();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // Hang guard, far beyond the 138 cycles needed
    initial begin
        #100000;
        fail_count++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        logic [31:0] rd, dm;
        logic        er;
        int          np, nb;
        presetn = 1'b0;
        strap   = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Identification and memory kind, back to back
        foreach (adr_tab[k]) begin
            i_dbg.xfer(1'b0, adr_tab[k], 32'h0, rd, er);
            check($sformatf("reg %h", adr_tab[k]), exp_tab[k], rd);
        end
        i_dbg.idle();
        $display("Test ident reads done");
        // Writes of all ones, each read back at once
        foreach (adr_tab[k]) begin
            i_dbg.xfer(1'b1, adr_tab[k], 32'hFFFFFFFF, rd, er);
            check("write error", 32'h0, {31'h0, er});
            i_dbg.xfer(1'b0, adr_tab[k], 32'h0, rd, er);
            check($sformatf("after write %h", adr_tab[k]), exp_tab[k], rd);
        end
        i_dbg.idle();
        $display("Test write ignore done");
        // Strap set then cleared shows in memory kind bit 0
        for (int s = 1; s >= 0; s--) begin
            strap <= s[0];
            repeat (3) @(posedge pclk);
            i_dbg.xfer(1'b0, 12'hFCC, 32'h0, rd, er);
            check("memory kind", {31'h0, s[0]}, rd);
            i_dbg.idle();
        end
        $display("Test memory kind done");
        // Entry words, end marker and reserved areas
        foreach (ent_tab[k]) begin
            i_dbg.xfer(1'b0, 12'(k * 4), 32'h0, rd, er);
            check($sformatf("entry %0d", k), ent_tab[k], rd);
        end
        foreach (zero_tab[k]) begin
            i_dbg.xfer(1'b0, zero_tab[k], 32'h0, rd, er);
            check($sformatf("reserved %h", zero_tab[k]), 32'h0, rd);
        end
        i_dbg.idle();
        $display("Test entries done");
        // Discovery walk finds domains 0 and 1 and one present entry without a domain
        i_dbg.walk(dm, np, nb);
        check("domain set", 32'h3, dm);
        check("unnumbered entries", 32'h1, 32'(np));
        check("invalid numbers", 32'h0, 32'(nb));
        $display("Test walk done");
        summarize();
    end

endmodule : testbench
